//--- shared/acs_cfg.svh
// Purpose: Offsets, field positions, reset values and timing for the
//          conversion sequencer.
// Assumes: Byte addresses on a 32-bit AHB-Lite bus.
// Notes:   Definitions only.
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

`define ACS_OFS_RES_HI     12'h000
`define ACS_OFS_RES_LO     12'h004
`define ACS_OFS_CTRL0      12'h008
`define ACS_OFS_CTRL1      12'h00C
`define ACS_OFS_CTRL2      12'h010
`define ACS_OFS_STAT       12'h014
`define ACS_OFS_PORT       12'h018

// Channel and run control
`define ACS_C0_ON          0
`define ACS_C0_GO          1
`define ACS_C0_MASK        8'h3F
// Reference and pin configuration
`define ACS_C1_MASK        8'h3F
`define ACS_PCFG_ANALOG    4'h0
`define ACS_PCFG_DIGITAL   4'h7
// Timing and format
`define ACS_C2_MASK        8'hBF
`define ACS_C2_JUST        7
`define ACS_STAT_DONE      0
`define ACS_CCP_SPECIAL    4'hB

`define ACS_CONV_TADS      4'hB
`define ACS_WAIT_TADS      4'h2
`define ACS_DISCH_TADS     4'h1
`define ACS_RC_TAD_NS      1200
`define ACS_CLK_NS         5
`define ACS_RC_TAD_CYC     ((`ACS_RC_TAD_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_RC_START_CYC   8'h04

`endif

//--- shared/acs_pkg.sv
// Purpose: Types shared by the conversion sequencer.
// Assumes: Nothing beyond the cfg header.
// Notes:   State encoding left to the tool.
package acs_pkg;

   typedef enum logic [2:0] {
      ACS_IDLE,
      ACS_DELAY,
      ACS_DISCH,
      ACS_ACQ,
      ACS_CONV,
      ACS_WAIT
   } acs_state_e;

   typedef struct packed {
      acs_state_e  state;
      logic [7:0]  res_hi;
      logic [7:0]  res_lo;
      logic [7:0]  ctrl0;
      logic [7:0]  ctrl1;
      logic [7:0]  ctrl2;
      logic        done_flag;
      logic [10:0] tad_cnt;
      logic [4:0]  bit_cnt;
      logic [9:0]  sar;
      logic        hsel_d;
      logic        hwrite_d;
      logic [11:0] haddr_d;
      logic [31:0] hrdata;
      logic        pcfg_init;
   } acs_state_s;

endpackage

//--- src/acs_sequencer.sv
// Purpose: Sequencer and register file around a 10-bit SAR converter.
// Assumes: Synchronous inputs, AHB-Lite single word transfers.
// Notes:   Zero wait states; comparator decision is an input.
`timescale 1ns/10ps
`include "acs_cfg.svh"

// Behaviour
// - Clock select picks oscillator divider or RC
// - Conversion lasts eleven bit periods
// - Completion loads result, clears request, flags
// - Programmed acquisition precedes automatic conversion
// - Code zero delays start one instruction
// - Code zero starts after following instruction
// - Code 010 gives four bit periods
// - Clearing request aborts, results untouched
// - Two bit period wait after conversion
// - Then acquisition restarts automatically
// - Discharge capacitor array before each sample
// - Compare trigger in mode 1011 starts conversion
// - Compare trigger resets timer counter
// - Trigger ignored when off, timer still reset
// - Sequencing ignores channel and direction bits
// - Analog pins read zero on port
// - Strap sets reset value of pin config
module acs_sequencer
   import acs_pkg::*;
#(
   parameter int unsigned OSC_DIV_W = 11,
   parameter int unsigned INSN_CYC  = 4
)(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        rc_tick,
   input  wire logic        cmp_decision,
   input  wire logic        ccp_special_event,
   input  wire logic [3:0]  compare_unit_mode,
   input  wire logic        portb_analog_reset_select,
   input  wire logic [12:0] pin_level,
   output logic             sample_switch,
   output logic             discharge,
   output logic [9:0]       sar_code,
   output logic [3:0]       channel_select,
   output logic             timer_counter_reset,
   output logic             conversion_done_irq_flag
);

   acs_state_s r, n;
   logic       tad_tick;
   logic       go_wr;
   logic       go_clr;
   logic       trig;
   logic [10:0] tad_div;
   logic [4:0]  acq_tads;
   logic [7:0]  wval;
   logic [12:0] analog_mask;

   ////////////////////////////////////////////////////////////////////
   // Clock select and acquisition lookups
   function automatic logic [10:0] div_of(input logic [2:0] cs);
      case (cs)
         3'h0:    div_of = 11'h002;
         3'h1:    div_of = 11'h008;
         3'h2:    div_of = 11'h020;
         3'h4:    div_of = 11'h004;
         3'h5:    div_of = 11'h010;
         3'h6:    div_of = 11'h040;
         default: div_of = 11'h000;
      endcase
   endfunction

   function automatic logic [4:0] acq_of(input logic [2:0] aq);
      case (aq)
         3'h1:    acq_of = 5'h02;
         3'h2:    acq_of = 5'h04;
         3'h3:    acq_of = 5'h06;
         3'h4:    acq_of = 5'h08;
         3'h5:    acq_of = 5'h0C;
         3'h6:    acq_of = 5'h10;
         3'h7:    acq_of = 5'h14;
         default: acq_of = 5'h00;
      endcase
   endfunction

   function automatic logic [12:0] amask(input logic [3:0] pc);
      logic [12:0] m;
      m = '0;
      for (int i = 0; i < 13; i++) begin
         m[i] = (int'(pc) <= 14 - i) && (pc != 4'hF);
      end
      amask = m;
   endfunction

   assign tad_div  = div_of(r.ctrl2[2:0]);
   assign acq_tads = acq_of(r.ctrl2[5:3]);
   // RC codes step on the RC tick, others on divided oscillator
   assign tad_tick = (tad_div == 11'h000) ? rc_tick :
                     (r.tad_cnt == tad_div - 11'h001);
   assign analog_mask = amask(r.ctrl1[3:0]);
   assign trig = ccp_special_event &&
                 (compare_unit_mode == `ACS_CCP_SPECIAL);

   ////////////////////////////////////////////////////////////////////
   // Bus decode
   assign wval = hwdata[7:0];
   assign go_wr  = r.hsel_d && r.hwrite_d && r.haddr_d == `ACS_OFS_CTRL0 &&
                   wval[`ACS_C0_GO];
   assign go_clr = r.hsel_d && r.hwrite_d && r.haddr_d == `ACS_OFS_CTRL0 &&
                   !wval[`ACS_C0_GO];

   always_comb begin
      n = r;
      n.hsel_d   = hsel && hready && htrans[1];
      n.hwrite_d = hwrite;
      n.haddr_d  = haddr[11:0];
      if (!r.pcfg_init) begin
         n.pcfg_init = 1'b1;
         n.ctrl1[3:0] = portb_analog_reset_select ? `ACS_PCFG_ANALOG
                                                  : `ACS_PCFG_DIGITAL;
      end
      if (r.hsel_d && r.hwrite_d) begin
         case (r.haddr_d)
            `ACS_OFS_RES_HI: n.res_hi = wval;
            `ACS_OFS_RES_LO: n.res_lo = wval;
            `ACS_OFS_CTRL0:  n.ctrl0  = wval & `ACS_C0_MASK;
            `ACS_OFS_CTRL1:  n.ctrl1  = wval & `ACS_C1_MASK;
            `ACS_OFS_CTRL2:  n.ctrl2  = wval & `ACS_C2_MASK;
            `ACS_OFS_STAT:   n.done_flag = wval[`ACS_STAT_DONE];
            default: ;
         endcase
      end
      // trigger only acts while powered on
      if (trig && r.ctrl0[`ACS_C0_ON]) begin
         n.ctrl0[`ACS_C0_GO] = 1'b1;
      end
      n.tad_cnt = tad_tick ? 11'h000 : r.tad_cnt + 11'h001;
      case (r.state)
         ACS_IDLE: begin
            n.tad_cnt = 11'h000;
            n.bit_cnt = 5'h00;
            if (n.ctrl0[`ACS_C0_GO] && r.ctrl0[`ACS_C0_ON]) begin
               // code zero defers by one instruction time
               n.state = (acq_tads == 5'h00) ? ACS_DELAY : ACS_DISCH;
            end
         end
         ACS_DELAY: begin
            // Discharge must start on a fresh bit period
            n.tad_cnt = 11'h000;
            n.bit_cnt = r.bit_cnt + 5'h01;
            if (r.bit_cnt == 5'(INSN_CYC - 1)) begin
               n.bit_cnt = 5'h00;
               n.state   = ACS_DISCH;
            end
         end
         ACS_DISCH: begin
            // First RC tick only starts the clock, so no partial period
            if (tad_tick && tad_div == 11'h000 && r.bit_cnt == 5'h00) begin
               n.bit_cnt = 5'h01;
            end else if (tad_tick) begin
               n.state   = (acq_tads == 5'h00) ? ACS_CONV : ACS_ACQ;
               n.bit_cnt = 5'h00;
               n.sar     = 10'h200;
            end
         end
         ACS_ACQ: begin
            if (tad_tick) begin
               n.bit_cnt = r.bit_cnt + 5'h01;
               if (r.bit_cnt == acq_tads - 5'h01) begin
                  n.state   = ACS_CONV;
                  n.bit_cnt = 5'h00;
               end
            end
         end
         ACS_CONV: begin
            if (tad_tick) begin
               n.bit_cnt = r.bit_cnt + 5'h01;
               if (r.bit_cnt >= 5'h01 && r.bit_cnt <= 5'h0A) begin
                  for (int b = 0; b < 10; b++) begin
                     if (b == 10 - int'(r.bit_cnt)) begin
                        n.sar[b] = cmp_decision;
                        if (b > 0) n.sar[b-1] = 1'b1;
                     end
                  end
               end
               if (r.bit_cnt == 5'(`ACS_CONV_TADS) - 5'h01) begin
                  if (r.ctrl2[`ACS_C2_JUST]) begin
                     n.res_hi = {6'h00, n.sar[9:8]};
                     n.res_lo = n.sar[7:0];
                  end else begin
                     n.res_hi = n.sar[9:2];
                     n.res_lo = {n.sar[1:0], 6'h00};
                  end
                  n.ctrl0[`ACS_C0_GO] = 1'b0;
                  n.done_flag = 1'b1;
                  n.state     = ACS_WAIT;
                  n.bit_cnt   = 5'h00;
               end
            end
         end
         ACS_WAIT: begin
            if (tad_tick) begin
               n.bit_cnt = r.bit_cnt + 5'h01;
               if (r.bit_cnt == 5'(`ACS_WAIT_TADS) - 5'h01) begin
                  n.state = ACS_IDLE;
               end
            end
         end
         default: n.state = ACS_IDLE;
      endcase
      if ((go_clr || !n.ctrl0[`ACS_C0_ON]) &&
          r.state != ACS_IDLE && r.state != ACS_WAIT) begin
         n.ctrl0[`ACS_C0_GO] = 1'b0;
         n.state   = ACS_WAIT;
         n.bit_cnt = 5'h00;
         n.res_hi  = (r.hsel_d && r.hwrite_d &&
                      r.haddr_d == `ACS_OFS_RES_HI) ? wval : r.res_hi;
         n.res_lo  = (r.hsel_d && r.hwrite_d &&
                      r.haddr_d == `ACS_OFS_RES_LO) ? wval : r.res_lo;
      end
      if (!r.ctrl0[`ACS_C0_ON] && r.state == ACS_IDLE) begin
         n.ctrl0[`ACS_C0_GO] = 1'b0;
      end
      n.hrdata = 32'h0000_0000;
      if (hsel && hready && htrans[1] && !hwrite) begin
         case (haddr[11:0])
            `ACS_OFS_RES_HI: n.hrdata[7:0] = n.res_hi;
            `ACS_OFS_RES_LO: n.hrdata[7:0] = n.res_lo;
            `ACS_OFS_CTRL0:  n.hrdata[7:0] = n.ctrl0;
            `ACS_OFS_CTRL1:  n.hrdata[7:0] = n.ctrl1;
            `ACS_OFS_CTRL2:  n.hrdata[7:0] = n.ctrl2;
            `ACS_OFS_STAT:   n.hrdata[0]   = n.done_flag;
            `ACS_OFS_PORT:   n.hrdata[12:0] = pin_level & ~analog_mask;
            default: ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs
   assign hrdata    = r.hrdata;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   // No sampling during the post-conversion wait
   assign sample_switch = (r.state == ACS_IDLE || r.state == ACS_DELAY ||
                           r.state == ACS_ACQ);
   assign discharge = (r.state == ACS_DISCH);
   assign sar_code  = r.sar;
   assign channel_select = r.ctrl0[5:2];
   assign timer_counter_reset = trig;
   assign conversion_done_irq_flag = r.done_flag;

endmodule

//--- tb/acs_analog_model.sv
// Purpose: Comparator and RC oscillator beside the converter.
// Assumes: Level held steady through a conversion.
// Notes:   Decision high while trial code is not above level.
`timescale 1ns/10ps
module acs_analog_model #(
   parameter int RC_CYC = 20
)(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic [9:0] level,
   input  wire logic [9:0] sar_code,
   output logic            cmp_decision,
   output logic            rc_tick
);
   int cnt;
   assign cmp_decision = (sar_code <= level);
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 0;
         rc_tick <= 1'h0;
      end else begin
         cnt <= (cnt == RC_CYC - 1) ? 0 : cnt + 1;
         rc_tick <= (cnt == RC_CYC - 1);
      end
   end
endmodule

//--- tb/acs_sequencer_assertions.sv
// Purpose: Port checks for the conversion sequencer.
// Assumes: One clock, reset active low.
// Notes:   Bound to the sequencer below.
`timescale 1ns/10ps
`include "acs_cfg.svh"
module acs_sequencer_assertions (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        ccp_special_event,
   input wire logic [3:0]  compare_unit_mode,
   input wire logic        sample_switch,
   input wire logic        discharge,
   input wire logic [3:0]  channel_select,
   input wire logic        timer_counter_reset,
   input wire logic        conversion_done_irq_flag
);
   logic wr, wr_st, wr_c0, conv;
   assign wr = hsel && hready && hwrite && htrans[1];
   assign wr_st = wr && haddr[11:0] == `ACS_OFS_STAT;
   assign wr_c0 = wr && haddr[11:0] == `ACS_OFS_CTRL0;
   assign conv = !sample_switch && !discharge;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////
   sequence s_trig;
      ccp_special_event && compare_unit_mode == `ACS_CCP_SPECIAL;
   endsequence
   sequence s_done;
      $rose(conversion_done_irq_flag);
   endsequence
   a_trig_reset: assert property (s_trig |-> timer_counter_reset)
      else $error("no timer reset on trigger");
   a_reset_cause: assert property (timer_counter_reset |-> s_trig)
      else $error("timer reset without trigger");
   a_disch_excl: assert property (discharge |-> !sample_switch)
      else $error("discharge while sampling");
   a_disch_len: assert property ($rose(discharge) |-> discharge[*2])
      else $error("discharge too short");
   a_flag_clear: assert property (
      $fell(conversion_done_irq_flag) |-> $past(wr_st, 2))
      else $error("done flag fell without a write");
   a_flag_set: assert property (s_done |-> $past(conv))
      else $error("done flag set outside conversion");
   a_wait_hold: assert property (s_done |-> !sample_switch[*4])
      else $error("acquisition too soon after conversion");
   a_chan_write: assert property (
      $changed(channel_select) |-> $past(wr_c0, 2))
      else $error("channel changed without a write");
endmodule
bind acs_sequencer acs_sequencer_assertions chk_u (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .ccp_special_event(ccp_special_event),
   .compare_unit_mode(compare_unit_mode),
   .sample_switch(sample_switch), .discharge(discharge),
   .channel_select(channel_select),
   .timer_counter_reset(timer_counter_reset),
   .conversion_done_irq_flag(conversion_done_irq_flag));

//--- tb/adc_conversion_sequencer_bench.sv
// Purpose: Self-checking bench for the conversion sequencer.
// Assumes: Oscillator is hclk; slave answers with hreadyout.
// Notes:   Read results checked from a queue by a bus monitor.
`timescale 1ns/10ps
`include "acs_cfg.svh"
module adc_conversion_sequencer_bench;
   logic        hclk, hreadyout, hresp, rc_tick, cmp, smp, dis, trst;
   logic        done_f, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
   logic        ccp_ev = 1'h0, rdp = 1'h0, strap = 1'h1;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q[$];
   logic [1:0]  htrans = 2'h0;
   logic [3:0]  ccp_mode = 4'h0, chan, ch;
   logic [12:0] pins = 13'h0;
   logic [9:0]  sar, level = 10'h0;
   logic [7:0]  r1, r2;
   int          err_total = 0, comparisons = 0, seed = 24647;
   int          n, k, d, a, c, w, t;
   int          dv[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
   wire  [2:0]  mon = {done_f, smp, dis};
   acs_sequencer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .rc_tick(rc_tick),
      .cmp_decision(cmp), .ccp_special_event(ccp_ev),
      .compare_unit_mode(ccp_mode), .portb_analog_reset_select(strap),
      .pin_level(pins), .sample_switch(smp), .discharge(dis),
      .sar_code(sar), .channel_select(chan), .timer_counter_reset(trst),
      .conversion_done_irq_flag(done_f));
   acs_analog_model far_u (.hclk(hclk), .hresetn(hresetn), .level(level),
      .sar_code(sar), .cmp_decision(cmp), .rc_tick(rc_tick));
   initial begin
      hclk = 1'h0;
      forever #2.5 hclk = ~hclk;
   end
   ////////////////////////////////////////////////////////////
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task end_of_test;
      $display("compared %0d, mismatched %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Count edges while a watched output keeps its value
   task cnt(input int s, input logic v, output int len);
      len = 0;
      while (mon[s] === v && len < 5000) begin
         @(posedge hclk);
         len++;
      end
      if (len >= 5000) begin
         err_total++;
         end_of_test;
      end
   endtask
   task xfer(input logic wr, input logic [11:0] ad, input logic [31:0] dt);
      hsel <= 1'h1;
      hwrite <= wr;
      htrans <= 2'h2;
      haddr <= {20'h0, ad};
      repeat (2) begin
         t = 0;
         do begin
            @(posedge hclk);
            t++;
         end while (hreadyout !== 1'h1 && t < 100);
         if (hreadyout !== 1'h1) begin
            err_total++;
            end_of_test;
         end
         if (htrans[1]) begin
            htrans <= 2'h0;
            hwdata <= dt;
         end
      end
   endtask
   task rd(input logic [11:0] ad, input logic [31:0] e);
      q.push_back(e);
      xfer(1'h0, ad, 32'h0);
   endtask
   task pulse(input logic [3:0] m, input logic e);
      ccp_mode <= m;
      ccp_ev <= 1'h1;
      @(posedge hclk);
      chk(trst, e);
      ccp_ev <= 1'h0;
      @(posedge hclk);
   endtask
   task rst;
      hresetn <= 1'h0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'h1;
      repeat (2) @(posedge hclk);
   endtask
   task conv;
      cnt(0, 1'h0, n);
      cnt(0, 1'h1, d);
      cnt(1, 1'h1, a);
      cnt(2, 1'h0, c);
      cnt(1, 1'h0, w);
   endtask
   always @(posedge hclk) begin
      if (rdp && q.size() == 0)
         chk(1'h1, 1'h0);
      else if (rdp)
         chk(hrdata, q.pop_front());
      rdp <= hsel && hreadyout && htrans[1] && !hwrite;
   end
   ////////////////////////////////////////////////////////////
   initial begin
      pins <= 13'($random(seed));
      rst;
      rd(`ACS_OFS_CTRL1, 32'h0);
      rd(`ACS_OFS_PORT, 32'h0);
      rd(`ACS_OFS_CTRL2, 32'h0);
      strap <= 1'h0;
      rst;
      rd(`ACS_OFS_CTRL1, 32'h7);
      rd(`ACS_OFS_PORT, {pins[12:8], 8'h0});
      rd(12'h01C, 32'h0);
      $display("test reset finished");
      xfer(1'h1, `ACS_OFS_CTRL0, 32'h1);
      for (k = 0; k < 8; k++) begin
         level <= 10'($random(seed));
         ch = 4'($random(seed));
         xfer(1'h1, `ACS_OFS_CTRL2, {k[0], 4'h1, k[2:0]});
         xfer(1'h1, `ACS_OFS_CTRL0, {ch, 2'h3});
         conv;
         if (dv[k] > 0) begin
            chk(d, dv[k]);
            chk(a, 2 * dv[k]);
            chk(c, 11 * dv[k]);
            chk(w, 2 * dv[k]);
         end
         chk(chan, ch);
         chk(sar, level);
         rd(`ACS_OFS_CTRL0, {ch, 2'h1});
         rd(`ACS_OFS_STAT, 32'h1);
         rd(`ACS_OFS_RES_HI, k[0] ? level[9:8] : level[9:2]);
         rd(`ACS_OFS_RES_LO, k[0] ? level[7:0] : {level[1:0], 6'h0});
         xfer(1'h1, `ACS_OFS_STAT, 32'h0);
         rd(`ACS_OFS_STAT, 32'h0);
      end
      $display("test clocks finished");
      xfer(1'h1, `ACS_OFS_CTRL2, 32'h80);
      xfer(1'h1, `ACS_OFS_CTRL0, 32'h3);
      conv;
      chk(n inside {[4:6]}, 1'h1);
      chk(a, 0);
      chk(c, 22);
      $display("test manual finished");
      xfer(1'h1, `ACS_OFS_STAT, 32'h0);
      r1 = 8'($random(seed));
      r2 = 8'($random(seed));
      xfer(1'h1, `ACS_OFS_RES_HI, r1);
      xfer(1'h1, `ACS_OFS_RES_LO, r2);
      xfer(1'h1, `ACS_OFS_CTRL2, 32'h90);
      xfer(1'h1, `ACS_OFS_CTRL0, 32'h3);
      cnt(0, 1'h0, n);
      cnt(0, 1'h1, d);
      cnt(1, 1'h1, a);
      chk(a, 8);
      xfer(1'h1, `ACS_OFS_CTRL0, 32'h1);
      cnt(1, 1'h0, w);
      chk(w inside {[4:6]}, 1'h1);
      chk(done_f, 1'h0);
      rd(`ACS_OFS_RES_HI, r1);
      rd(`ACS_OFS_RES_LO, r2);
      $display("test abort finished");
      xfer(1'h1, `ACS_OFS_CTRL0, 32'h0);
      pulse(4'hB, 1'h1);
      pulse(4'hA, 1'h0);
      rd(`ACS_OFS_CTRL0, 32'h0);
      xfer(1'h1, `ACS_OFS_CTRL0, 32'h1);
      pulse(4'hB, 1'h1);
      conv;
      chk(a, 8);
      rd(`ACS_OFS_CTRL0, 32'h1);
      $display("test trigger finished");
      end_of_test;
   end
endmodule
